// ===== mpsc_pkg.sv
// Constants, types and carriers for the motor PWM state control block.
// Assumes one clock at oscillator rate; command and fault inputs come from analog comparators.
//
// Behaviour
// - Sleep holds gate drive output low
// - Any valid speed command wakes to run
// - Overvoltage or current fault in run enters fault state; command loss wins
// - Command stays active if pulsed every 2048
// - Manual input above 5.5 V selects manual
// - Manual mode ignores command pin as PWM
// - Reference switched on only in run
// - Command mode detected automatically, no setting
// - Gate drive reaches full 100 percent duty
// - Overvoltage clear resumes run; current fault needs sleep
// - Auto mode: 2048 counts without edge sleeps
// - Auto mode: falling command edge wakes run
// - Manual mode: opened manual input sleeps
package mpsc_pkg;

	// =========================================
	// Timing and widths
	localparam int CMD_TIMEOUT_COUNTS = 2048;
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] CMD_TIMEOUT_LAST = 12'(CMD_TIMEOUT_COUNTS - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
	localparam int DUTY_W = 9;
	localparam int PWM_W = 8;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 9'h100;
	localparam logic [PWM_W-1:0] PWM_ONE = 8'h01;
	localparam logic [PWM_W-1:0] PWM_ZERO = 8'h00;

	// =========================================
	// Synchroniser lane positions
	localparam int SYNC_W = 4;
	localparam int SY_CMD = 0;
	localparam int SY_MAN = 1;
	localparam int SY_OV = 2;
	localparam int SY_CF = 3;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 4'h1;

	// =========================================
	// Operating states
	typedef enum logic [1:0] {
		MPSC_SLEEP = 2'b00,
		MPSC_RUN = 2'b01,
		MPSC_FAULT = 2'b10
	} mpsc_state_t;

	// =========================================
	// Status carrier
	typedef struct packed {
		mpsc_state_t state;
		logic manual_mode;
		logic cmd_timeout;
		logic cf_latched;
	} mpsc_status_t;

	localparam mpsc_status_t STATUS_RESET = '{MPSC_SLEEP, 1'b0, 1'b0, 1'b0};

	// =========================================
	// Register sets
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		mpsc_status_t status;
		logic [PWM_W-1:0] pwm_cnt;
		logic gate;
		logic ref_en;
	} mpsc_top_regs_t;

	localparam mpsc_top_regs_t TOP_RESET = '{SYNC_RESET, SYNC_RESET, STATUS_RESET, PWM_ZERO, 1'b0, 1'b0};

	typedef struct packed {
		logic prev;
		logic [CNT_W-1:0] cnt;
		logic fall;
		logic timeout;
	} mpsc_watch_regs_t;

	localparam mpsc_watch_regs_t WATCH_RESET = '{1'b1, CNT_ZERO, 1'b0, 1'b0};

endpackage

// ===== mpsc_cmd_watch.sv
// Command edge detector and missing-command timeout.
// Assumes a synchronised command level on the same clock.
`timescale 1ns/1ps

module mpsc_cmd_watch import mpsc_pkg::*; (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// Command level and mode
	input wire logic i_cmd,
	input wire logic i_enable,
	// Events
	output logic o_fall,
	output logic o_timeout
);

	mpsc_watch_regs_t r;
	mpsc_watch_regs_t next_r;
	logic edge_seen;

	// =========================================
	// Next state
	always_comb begin
		next_r = r;
		next_r.prev = i_cmd;
		edge_seen = i_cmd != r.prev;
		next_r.fall = 1'b0;
		if (!i_enable) begin
			next_r.cnt = CNT_ZERO;
			next_r.timeout = 1'b0;
		end else if (edge_seen) begin
			next_r.cnt = CNT_ZERO;
			next_r.timeout = 1'b0;
			next_r.fall = r.prev & ~i_cmd;
		end else if (r.cnt == CMD_TIMEOUT_LAST) begin
			next_r.timeout = 1'b1;
		end else begin
			next_r.cnt = r.cnt + CNT_ONE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r <= WATCH_RESET;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_fall = r.fall;
	assign o_timeout = r.timeout;

	// =========================================
	// Checks
	property p_timeout_at_limit;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_enable && !edge_seen && r.cnt == CMD_TIMEOUT_LAST) |=> o_timeout;
	endproperty
	a_timeout_at_limit: assert property (p_timeout_at_limit) else $error("timeout not raised at limit");

	property p_edge_restarts;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_enable && edge_seen) |=> (r.cnt == CNT_ZERO && !o_timeout);
	endproperty
	a_edge_restarts: assert property (p_edge_restarts) else $error("edge did not restart counter");

endmodule // mpsc_cmd_watch

// ===== mpsc_state_ctrl.sv
// Sleep, run and fault control with mode detection and gate drive PWM.
// Assumes comparator outputs from the analog front end and a duty word in the clock domain.
`timescale 1ns/1ps

module mpsc_state_ctrl import mpsc_pkg::*; (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// Command pins (comparator levels)
	input wire logic i_pwm_cmd_in,
	input wire logic i_manual_cmd_hi,
	// Protection comparators
	input wire logic i_overvoltage,
	input wire logic i_current_fault,
	// Duty request, same clock
	input wire logic [DUTY_W-1:0] i_duty_cycle,
	// Outputs
	output logic o_gate_drive_out,
	output logic o_switched_ref_en,
	output mpsc_status_t o_status
);

	mpsc_top_regs_t r;
	mpsc_top_regs_t next_r;
	logic cmd_s;
	logic man_s;
	logic ov_s;
	logic cf_s;
	logic w_fall;
	logic w_timeout;
	logic cmd_lost;
	logic wake;
	mpsc_state_t st;

	function automatic logic pwm_high(input logic [DUTY_W-1:0] duty, input logic [PWM_W-1:0] cnt);
		pwm_high = (duty >= DUTY_FULL) || ({1'b0, cnt} < duty);
	endfunction

	assign cmd_s = r.s2[SY_CMD];
	assign man_s = r.s2[SY_MAN];
	assign ov_s = r.s2[SY_OV];
	assign cf_s = r.s2[SY_CF];
	assign st = r.status.state;

	// =========================================
	// Command watch
	mpsc_cmd_watch u_watch (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_cmd(cmd_s),
		.i_enable(!r.status.manual_mode),
		.o_fall(w_fall),
		.o_timeout(w_timeout)
	);

	// =========================================
	// Next state
	always_comb begin
		next_r = r;
		next_r.s1 = {i_current_fault, i_overvoltage, i_manual_cmd_hi, i_pwm_cmd_in};
		next_r.s2 = r.s1;
		next_r.status.manual_mode = man_s;
		next_r.status.cmd_timeout = w_timeout;
		// Command loss: manual opened, or auto command gone quiet
		cmd_lost = r.status.manual_mode ? !man_s : w_timeout;
		// Wake: manual level, or auto falling edge
		wake = man_s || (!r.status.manual_mode && w_fall);
		case (st)
			MPSC_SLEEP: begin
				next_r.status.cf_latched = 1'b0;
				if (wake) begin
					next_r.status.state = MPSC_RUN;
				end
			end
			MPSC_RUN: begin
				if (cmd_lost) begin
					next_r.status.state = MPSC_SLEEP;
				end else if (ov_s || cf_s) begin
					next_r.status.state = MPSC_FAULT;
					next_r.status.cf_latched = cf_s;
				end
			end
			MPSC_FAULT: begin
				if (cf_s) begin
					next_r.status.cf_latched = 1'b1;
				end
				if (cmd_lost) begin
					next_r.status.state = MPSC_SLEEP;
				end else if (!ov_s && !cf_s && !r.status.cf_latched) begin
					next_r.status.state = MPSC_RUN;
				end
			end
			default: begin
				next_r.status.state = MPSC_SLEEP;
			end
		endcase
		next_r.pwm_cnt = r.pwm_cnt + PWM_ONE;
		next_r.ref_en = next_r.status.state == MPSC_RUN;
		next_r.gate = (next_r.status.state == MPSC_RUN) && pwm_high(i_duty_cycle, next_r.pwm_cnt);
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r <= TOP_RESET;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_gate_drive_out = r.gate;
	assign o_switched_ref_en = r.ref_en;
	assign o_status = r.status;

	// =========================================
	// Checks
	property p_sleep_gate_low;
		@(posedge i_clk) disable iff (i_srst)
		(st != MPSC_RUN) |-> !o_gate_drive_out;
	endproperty
	a_sleep_gate_low: assert property (p_sleep_gate_low) else $error("gate high outside run");

	property p_ref_in_run;
		@(posedge i_clk) disable iff (i_srst)
		o_switched_ref_en == (st == MPSC_RUN);
	endproperty
	a_ref_in_run: assert property (p_ref_in_run) else $error("reference switch disagrees with state");

	sequence s_auto_sleep_fall;
		i_ce && st == MPSC_SLEEP && !r.status.manual_mode && w_fall;
	endsequence
	property p_auto_wake;
		@(posedge i_clk) disable iff (i_srst)
		s_auto_sleep_fall |=> (st == MPSC_RUN);
	endproperty
	a_auto_wake: assert property (p_auto_wake) else $error("falling edge did not wake");

	property p_manual_wake;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && st == MPSC_SLEEP && man_s) |=> (st == MPSC_RUN);
	endproperty
	a_manual_wake: assert property (p_manual_wake) else $error("manual command did not wake");

	property p_fault_entry;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && st == MPSC_RUN && !cmd_lost && (ov_s || cf_s)) |=> (st == MPSC_FAULT);
	endproperty
	a_fault_entry: assert property (p_fault_entry) else $error("fault not entered");

	property p_cf_needs_sleep;
		@(posedge i_clk) disable iff (i_srst)
		(st == MPSC_FAULT && r.status.cf_latched) |=> (st != MPSC_RUN);
	endproperty
	a_cf_needs_sleep: assert property (p_cf_needs_sleep) else $error("current fault left without sleep");

	property p_auto_timeout_sleep;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && st == MPSC_RUN && !r.status.manual_mode && w_timeout) |=> (st == MPSC_SLEEP);
	endproperty
	a_auto_timeout_sleep: assert property (p_auto_timeout_sleep) else $error("timeout did not sleep");

	property p_manual_open_sleep;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && st == MPSC_RUN && r.status.manual_mode && !man_s) |=> (st == MPSC_SLEEP);
	endproperty
	a_manual_open_sleep: assert property (p_manual_open_sleep) else $error("open manual input did not sleep");

	property p_manual_ignores_pwm;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && st == MPSC_RUN && r.status.manual_mode && man_s && !ov_s && !cf_s) |=> (st == MPSC_RUN);
	endproperty
	a_manual_ignores_pwm: assert property (p_manual_ignores_pwm) else $error("manual run left on command pin");

	property p_mode_tracks;
		@(posedge i_clk) disable iff (i_srst)
		i_ce |=> (o_status.manual_mode == $past(man_s));
	endproperty
	a_mode_tracks: assert property (p_mode_tracks) else $error("mode not detected");

	property p_full_duty;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_duty_cycle >= DUTY_FULL) |=> (o_gate_drive_out == (st == MPSC_RUN));
	endproperty
	a_full_duty: assert property (p_full_duty) else $error("full duty not continuous");

	property p_zero_duty;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_duty_cycle == {DUTY_W{1'b0}}) |=> !o_gate_drive_out;
	endproperty
	a_zero_duty: assert property (p_zero_duty) else $error("gate high at zero duty");

	property p_fault_cmd_loss;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && st == MPSC_FAULT && cmd_lost) |=> (st == MPSC_SLEEP);
	endproperty
	a_fault_cmd_loss: assert property (p_fault_cmd_loss) else $error("fault did not sleep on command loss");

	property p_ov_clear_resume;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && st == MPSC_FAULT && !cmd_lost && !ov_s && !cf_s && !r.status.cf_latched) |=> (st == MPSC_RUN);
	endproperty
	a_ov_clear_resume: assert property (p_ov_clear_resume) else $error("fault not left after clear");

	property p_sleep_clears_cf;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && st == MPSC_SLEEP) |=> !o_status.cf_latched;
	endproperty
	a_sleep_clears_cf: assert property (p_sleep_clears_cf) else $error("sleep kept current fault");

	property p_timeout_flag;
		@(posedge i_clk) disable iff (i_srst)
		i_ce |=> (o_status.cmd_timeout == $past(w_timeout));
	endproperty
	a_timeout_flag: assert property (p_timeout_flag) else $error("timeout flag not reported");

	property p_manual_no_fall;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && r.status.manual_mode) |=> !w_fall;
	endproperty
	a_manual_no_fall: assert property (p_manual_no_fall) else $error("command edge seen in manual mode");

	property p_freeze;
		@(posedge i_clk) disable iff (i_srst)
		(!i_ce) |=> ($stable(o_status) && $stable(o_gate_drive_out) && $stable(o_switched_ref_en));
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

endmodule // mpsc_state_ctrl

// ===== mpsc_cmd_src.sv
// Command source model: PWM pulses, manual level or idle pin.
// Assumes the bench sets mode and period; pin idles high through the pull-up.
`timescale 1ns/1ps

module mpsc_cmd_src (
	// Clock and controls
	input wire logic i_clk,
	input wire logic [1:0] i_mode,
	input wire logic [11:0] i_period,
	// Pins
	output logic o_pwm_cmd,
	output logic o_manual_hi
);
	logic [11:0] cnt = 12'h000;
	initial begin
		o_pwm_cmd = 1'b1;
		o_manual_hi = 1'b0;
	end
	// =========================================
	// Pin drive
	always @(posedge i_clk) begin
		cnt <= (cnt >= i_period) ? 12'h000 : cnt + 12'h001;
		o_manual_hi <= (i_mode == 2'h2);
		if (i_mode == 2'h1)
			o_pwm_cmd <= (cnt != 12'h000);
		else if (i_mode == 2'h2)
			o_pwm_cmd <= ~o_pwm_cmd;
		else
			o_pwm_cmd <= 1'b1;
	end
endmodule // mpsc_cmd_src

// ===== tb_mpsc_state_ctrl.sv
// Self-checking bench for the state control block.
// Assumes one 100 MHz clock; the source model drives the command pins.
`timescale 1ns/1ps

module tb_mpsc_state_ctrl import mpsc_pkg::*;;
	logic i_clk = 1'b0, i_srst = 1'b1, i_ov = 1'b0, i_cf = 1'b0, ce = 1'b1;
	logic pwm_cmd, man_hi, gate, ref_en;
	logic [DUTY_W-1:0] duty = 9'h000;
	logic [1:0] mode = 2'h0;
	logic [11:0] period = 12'h032;
	mpsc_status_t st;
	mpsc_state_t exp_q[$];
	mpsc_state_t last_st = MPSC_SLEEP;
	int fails = 0, cmp_count = 0, sleep_hi = 0, n, hi;
	always #5 i_clk = ~i_clk;
	mpsc_state_ctrl mpsc_state_ctrl_i (.i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_pwm_cmd_in(pwm_cmd),
		.i_manual_cmd_hi(man_hi), .i_overvoltage(i_ov), .i_current_fault(i_cf), .i_duty_cycle(duty),
		.o_gate_drive_out(gate), .o_switched_ref_en(ref_en), .o_status(st));
	mpsc_cmd_src mpsc_cmd_src_i (.i_clk(i_clk), .i_mode(mode), .i_period(period), .o_pwm_cmd(pwm_cmd),
		.o_manual_hi(man_hi));
	// =========================================
	// Checking
	task check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		if (!i_srst && st.state === MPSC_SLEEP && gate !== 1'b0)
			sleep_hi++;
		if (!i_srst && st.state !== last_st) begin
			last_st <= st.state;
			check("state", st.state, (exp_q.size() > 0) ? exp_q.pop_front() : last_st);
			check("ref_en", ref_en, st.state === MPSC_RUN);
		end
	end
	task wait_state(input mpsc_state_t s);
		n = 0;
		while (st.state !== s) begin
			@(posedge i_clk);
			n++;
			if (n > 3000) begin
				check("wait state", st.state, s);
				conclude();
			end
		end
	endtask
	task gate_count(input logic [DUTY_W-1:0] d, input int exp);
		duty <= d;
		repeat (4) @(posedge i_clk);
		hi = 0;
		repeat (256) begin
			@(posedge i_clk);
			hi += (gate === 1'b1);
		end
		check("gate count", hi, exp);
	endtask
	task set_mode(input logic [1:0] m, input mpsc_state_t s);
		exp_q.push_back(s);
		mode <= m;
		wait_state(s);
	endtask
	// =========================================
	// Tests
	initial begin
		void'($urandom(32'hf27d));
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		check("reset", st, STATUS_RESET);
		$display("test reset done");
		period <= 12'($urandom_range(20, 200));
		set_mode(2'h1, MPSC_RUN);
		n = $urandom_range(1, 255);
		gate_count(9'(n), n);
		n = $urandom_range(256, 511);
		gate_count(9'(n), 256);
		$display("test auto wake and duty done");
		period <= 12'h7D0;
		repeat (5000) @(posedge i_clk);
		check("still run", st.state, MPSC_RUN);
		period <= 12'h032;
		$display("test slow pulses done");
		exp_q.push_back(MPSC_FAULT);
		i_ov <= 1'b1;
		wait_state(MPSC_FAULT);
		exp_q.push_back(MPSC_RUN);
		i_ov <= 1'b0;
		wait_state(MPSC_RUN);
		exp_q.push_back(MPSC_FAULT);
		ce <= 1'b0;
		i_cf <= 1'b1;
		repeat (50) @(posedge i_clk);
		check("frozen", st.state, MPSC_RUN);
		ce <= 1'b1;
		wait_state(MPSC_FAULT);
		i_cf <= 1'b0;
		repeat (200) @(posedge i_clk);
		check("cf latched", st.cf_latched, 1'b1);
		set_mode(2'h0, MPSC_SLEEP);
		check("timeout lower", n >= 1990, 1'b1);
		check("timeout upper", n <= 2060, 1'b1);
		check("cmd timeout", st.cmd_timeout, 1'b1);
		@(posedge i_clk);
		check("cf cleared", st.cf_latched, 1'b0);
		$display("test faults and timeout done");
		set_mode(2'h1, MPSC_RUN);
		mode <= 2'h2;
		repeat (3000) @(posedge i_clk);
		check("manual mode", st.manual_mode, 1'b1);
		check("manual run", st.state, MPSC_RUN);
		set_mode(2'h0, MPSC_SLEEP);
		set_mode(2'h2, MPSC_RUN);
		set_mode(2'h0, MPSC_SLEEP);
		check("gate in sleep", sleep_hi, 0);
		$display("test manual done");
		conclude();
	end
endmodule // tb_mpsc_state_ctrl
